// ==== common/dbmsp_pkg.sv ====
`default_nettype none
package dbmsp_pkg;
   localparam int unsigned NUM_CHAN = 2;
   localparam int unsigned ADDR_W = 8;
   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_CMD_PRI = 8'h00;
   localparam logic [7:0] IDX_STAT_PRI = 8'h02;
   localparam logic [7:0] IDX_PTR_PRI = 8'h04;
   localparam logic [7:0] IDX_CMD_SEC = 8'h08;
   localparam logic [7:0] IDX_STAT_SEC = 8'h0A;
   localparam logic [7:0] IDX_PTR_SEC = 8'h0C;
   localparam logic [7:0] IDX_MODE = 8'h10;
   // status fields
   localparam int unsigned STAT_SIMPLEX = 7;
   localparam int unsigned STAT_DRV1 = 6;
   localparam int unsigned STAT_DRV0 = 5;
   localparam int unsigned STAT_INT = 2;
   localparam int unsigned STAT_ERR = 1;
   localparam int unsigned STAT_ACT = 0;
   // command fields
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_DIR = 3;
   // mode fields: io enable, then one native-mode bit per channel
   localparam int unsigned MODE_IOEN = 0;
   localparam int unsigned MODE_NATIVE0 = 1;
   // end_of_table_flag: bit 7 of the last descriptor byte, i.e. bit 31 of dword 1
   localparam int unsigned EOT_BIT = 31;
   // reset values
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [31:0] PTR_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // per-channel engine inputs
   typedef struct packed {
      logic drvIrq;
      logic bufEmpty;
      logic regionDone;
      logic [31:0] descWord1;
      logic memError;
   } dbmsp_eng_t;

   // per-channel control towards the engine
   typedef struct packed {
      logic startPulse;
      logic running;
      logic dirWrite;
   } dbmsp_ctl_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } dbmsp_bus_t;

   function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
      byteAddr = {idx[5:0], 2'b00};
   endfunction
endpackage
`default_nettype wire

// ==== hw/dbmsp_edge.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbmsp_edge (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // level in, registered rising-edge pulse out
   input wire logic level,
   output logic rise
);
   logic prev_q;
   logic prev_d;
   logic rise_q;
   logic rise_d;

   always_comb
   begin
      prev_d = level;
      rise_d = level & ~prev_q;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         prev_q <= prev_d;
         rise_q <= rise_d;
      end
   end

   assign rise = rise_q;
endmodule
`default_nettype wire

// ==== hw/dbmsp_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbmsp_chan (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // engine side
   input wire dbmsp_pkg::dbmsp_eng_t eng,
   input wire logic drvRise,
   // register side
   input wire logic startSet,
   input wire logic startClr,
   input wire logic stWr,
   input wire logic [7:0] stData,
   // state
   output logic intFlag,
   output logic errFlag,
   output logic active,
   output logic [1:0] dmaCap
);
   logic int_q, int_d, err_q, err_d, act_q, act_d;
   logic irqPend_q, irqPend_d, eotPend_q, eotPend_d;
   logic [1:0] cap_q, cap_d;

   always_comb
   begin
      irqPend_d = irqPend_q | drvRise;
      int_d = int_q;
      err_d = err_q;
      act_d = act_q;
      eotPend_d = eotPend_q;
      cap_d = cap_q;
      if (stWr)
      begin
         cap_d = stData[dbmsp_pkg::STAT_DRV1:dbmsp_pkg::STAT_DRV0];
         if (stData[dbmsp_pkg::STAT_INT])
            int_d = 1'b0;
         if (stData[dbmsp_pkg::STAT_ERR])
            err_d = 1'b0;
      end
      // held back until buffered data reached memory; set beats clear
      if (irqPend_q && eng.bufEmpty)
      begin
         int_d = 1'b1;
         irqPend_d = drvRise;
      end
      if (startSet)
         act_d = 1'b1;
      if (act_q && eng.regionDone && eng.descWord1[dbmsp_pkg::EOT_BIT])
         eotPend_d = 1'b1;
      // after end of table, running only drops once the buffer is empty; clearing start or a memory fault drops it at once
      if (eotPend_q && eng.bufEmpty)
      begin
         act_d = 1'b0;
         eotPend_d = 1'b0;
      end
      if (startClr)
      begin
         act_d = 1'b0;
         eotPend_d = 1'b0;
      end
      // memory fault: stop, flag, no interrupt
      if (eng.memError)
      begin
         err_d = 1'b1;
         act_d = 1'b0;
         eotPend_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         int_q <= 1'b0;
         err_q <= 1'b0;
         act_q <= 1'b0;
         irqPend_q <= 1'b0;
         eotPend_q <= 1'b0;
         cap_q <= 2'h0;
      end
      else
      begin
         int_q <= int_d;
         err_q <= err_d;
         act_q <= act_d;
         irqPend_q <= irqPend_d;
         eotPend_q <= eotPend_d;
         cap_q <= cap_d;
      end
   end

   assign intFlag = int_q;
   assign errFlag = err_q;
   assign active = act_q;
   assign dmaCap = cap_q;
endmodule
`default_nettype wire

// ==== hw/dbmsp_top.sv ====
// Overview of operation
// - status bit 7 reads fixed simplex capability
// - status bits 6:5 are software-writable drive flags
// - status bits 4:3 read zero, ignore writes
// - bit 2 set on drive interrupt rising edge
// - interrupt flag cleared only by writing one
// - interrupt flag waits until buffers are flushed
// - bit 1 set on memory transfer failure
// - error flag cleared only by writing one
// - running flag set when start is written
// - running flag clears after final end-of-table region
// - running reads zero after end of table only once data flushed; stop or memory error clears it at once
// - per-channel 32-bit pointer, bits 1:0 reserved
// - compatibility mode drives legacy line, not INTx#
// - native mode drives INTx#, legacy line tri-stated
// - legacy lines tri-stated until io enable set
// - engine starts on start bit zero-to-one
// - descriptor bit 31 of dword 1 ends table
// - memory error stops, sets error, no interrupt
`timescale 1ns/1ns
`default_nettype none
module dbmsp_top #(
   parameter logic SIMPLEX_ONLY = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [dbmsp_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // engine, one entry per channel
   input wire dbmsp_pkg::dbmsp_eng_t eng [dbmsp_pkg::NUM_CHAN],
   output dbmsp_pkg::dbmsp_ctl_t ctl [dbmsp_pkg::NUM_CHAN],
   output logic [31:0] tablePtr [dbmsp_pkg::NUM_CHAN],
   // interrupt pins
   output logic [dbmsp_pkg::NUM_CHAN-1:0] legacyIrq,
   output logic [dbmsp_pkg::NUM_CHAN-1:0] legacyIrqOe,
   output logic intxNOe
);
   localparam int unsigned NC = dbmsp_pkg::NUM_CHAN;

   dbmsp_pkg::dbmsp_bus_t bus_q, bus_d;
   logic wait_q, wait_d;
   logic [31:0] rdat_q, rdat_d;
   logic wrEn;
   logic [NC-1:0] start_q, start_d, dir_q, dir_d;
   logic [NC-1:0] pulse_q, pulse_d;
   logic [NC-1:0] startSet, startClr, stWr, ptrWr;
   logic [31:0] ptr_q [NC];
   logic [31:0] ptr_d [NC];
   logic [7:0] mode_q, mode_d;
   logic [NC-1:0] drvRise, intFlag, errFlag, active;
   logic [1:0] dmaCap [NC];
   logic [NC-1:0] lIrq_q, lIrq_d, lOe_q, lOe_d;
   logic intx_q, intx_d;
   logic [7:0] statByte [NC];
   logic [NC-1:0] native;

   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      end
      laneMerge = r;
   endfunction

   // one wait cycle: decode in IDLE, answer in ACK
   always_comb
   begin
      bus_d = bus_q;
      wait_d = 1'b1;
      rdat_d = rdat_q;
      case (bus_q)
         dbmsp_pkg::BUS_IDLE:
         begin
            if (read || write)
            begin
               bus_d = dbmsp_pkg::BUS_ACK;
               wait_d = 1'b0;
               rdat_d = dbmsp_pkg::RD_ZERO;
               if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_CMD_PRI))
                  rdat_d = {24'h000000, 4'h0, dir_q[0], 2'h0, start_q[0]};
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_STAT_PRI))
                  rdat_d = {24'h000000, statByte[0]};
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_PTR_PRI))
                  rdat_d = ptr_q[0];
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_CMD_SEC))
                  rdat_d = {24'h000000, 4'h0, dir_q[1], 2'h0, start_q[1]};
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_STAT_SEC))
                  rdat_d = {24'h000000, statByte[1]};
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_PTR_SEC))
                  rdat_d = ptr_q[1];
               else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_MODE))
                  rdat_d = {24'h000000, mode_q};
            end
         end
         dbmsp_pkg::BUS_ACK:
         begin
            bus_d = dbmsp_pkg::BUS_IDLE;
         end
         default:
         begin
            bus_d = dbmsp_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_q <= dbmsp_pkg::BUS_IDLE;
         wait_q <= 1'b1;
         rdat_q <= dbmsp_pkg::RD_ZERO;
      end
      else
      begin
         bus_q <= bus_d;
         wait_q <= wait_d;
         rdat_q <= rdat_d;
      end
   end

   // writes land at the edge where waitrequest is seen low
   assign wrEn = write && (bus_q == dbmsp_pkg::BUS_ACK);

   always_comb
   begin
      start_d = start_q;
      dir_d = dir_q;
      mode_d = mode_q;
      startSet = '0;
      startClr = '0;
      stWr = '0;
      ptrWr = '0;
      for (int c = 0; c < NC; c++)
      begin
         ptr_d[c] = ptr_q[c];
      end
      if (wrEn && byteenable[0])
      begin
         if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_CMD_PRI))
         begin
            start_d[0] = writedata[dbmsp_pkg::CMD_START];
            dir_d[0] = writedata[dbmsp_pkg::CMD_DIR];
         end
         else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_CMD_SEC))
         begin
            start_d[1] = writedata[dbmsp_pkg::CMD_START];
            dir_d[1] = writedata[dbmsp_pkg::CMD_DIR];
         end
         else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_STAT_PRI))
            stWr[0] = 1'b1;
         else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_STAT_SEC))
            stWr[1] = 1'b1;
         else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_MODE))
            mode_d = writedata[7:0];
      end
      if (wrEn)
      begin
         if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_PTR_PRI))
            ptrWr[0] = 1'b1;
         else if (address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_PTR_SEC))
            ptrWr[1] = 1'b1;
      end
      for (int c = 0; c < NC; c++)
      begin
         if (ptrWr[c])
            ptr_d[c] = laneMerge(ptr_q[c], writedata, byteenable) & dbmsp_pkg::PTR_MASK;
         startSet[c] = start_d[c] & ~start_q[c];
         startClr[c] = ~start_d[c] & start_q[c];
      end
      pulse_d = startSet;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         start_q <= '0;
         dir_q <= '0;
         pulse_q <= '0;
         mode_q <= dbmsp_pkg::MODE_RST;
         for (int c = 0; c < NC; c++)
         begin
            ptr_q[c] <= dbmsp_pkg::PTR_RST;
         end
      end
      else
      begin
         start_q <= start_d;
         dir_q <= dir_d;
         pulse_q <= pulse_d;
         mode_q <= mode_d;
         for (int c = 0; c < NC; c++)
         begin
            ptr_q[c] <= ptr_d[c];
         end
      end
   end

   for (genvar c = 0; c < NC; c++)
   begin : g_chan
      dbmsp_edge u_edge (
         .clk(clk),
         .nrst(nrst),
         .level(eng[c].drvIrq),
         .rise(drvRise[c])
      );
      dbmsp_chan u_chan (
         .clk(clk),
         .nrst(nrst),
         .eng(eng[c]),
         .drvRise(drvRise[c]),
         .startSet(startSet[c]),
         .startClr(startClr[c]),
         .stWr(stWr[c]),
         .stData(writedata[7:0]),
         .intFlag(intFlag[c]),
         .errFlag(errFlag[c]),
         .active(active[c]),
         .dmaCap(dmaCap[c])
      );
      // bits 4:3 are hard zero, bit 7 is the fixed strap
      assign statByte[c] = {SIMPLEX_ONLY, dmaCap[c], 2'b00, intFlag[c], errFlag[c],
                            active[c]};
      assign native[c] = mode_q[dbmsp_pkg::MODE_NATIVE0 + c];
      assign ctl[c].startPulse = pulse_q[c];
      assign ctl[c].running = active[c];
      assign ctl[c].dirWrite = dir_q[c];
      assign tablePtr[c] = ptr_q[c];
   end

   // interrupt routing per channel mode
   always_comb
   begin
      lIrq_d = intFlag;
      lOe_d = '0;
      intx_d = 1'b0;
      for (int c = 0; c < NC; c++)
      begin
         lOe_d[c] = mode_q[dbmsp_pkg::MODE_IOEN] & ~native[c];
         intx_d = intx_d | (native[c] & intFlag[c]);
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lIrq_q <= '0;
         lOe_q <= '0;
         intx_q <= 1'b0;
      end
      else
      begin
         lIrq_q <= lIrq_d;
         lOe_q <= lOe_d;
         intx_q <= intx_d;
      end
   end

   assign readdata = rdat_q;
   assign waitrequest = wait_q;
   assign legacyIrq = lIrq_q;
   assign legacyIrqOe = lOe_q;
   assign intxNOe = intx_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence stReadAck;
      bus_q == dbmsp_pkg::BUS_IDLE && read &&
      address == dbmsp_pkg::byteAddr(dbmsp_pkg::IDX_STAT_PRI) ##1 !waitrequest;
   endsequence

   simplex_bit_a: assert property (stReadAck |-> readdata[7] == SIMPLEX_ONLY)
      else $error("status bit 7 does not show simplex strap");
   reserved_zero_a: assert property (stReadAck |-> readdata[4:3] == 2'b00)
      else $error("status bits 4:3 not zero");
   cap_write_a: assert property (wrEn && stWr[0] |=> dmaCap[0] == $past(writedata[6:5]))
      else $error("drive capable bits not stored");

   // edge detector plus pending stage: flag lands three edges after the rise
   sequence irqEdgeFlushed;
      !eng[1].drvIrq ##1 eng[1].drvIrq ##2 eng[1].bufEmpty;
   endsequence

   int_set_a: assert property (irqEdgeFlushed |=> intFlag[1])
      else $error("interrupt flag not set after drive edge");
   int_flush_a: assert property ($rose(intFlag[0]) |-> $past(eng[0].bufEmpty))
      else $error("interrupt flag set before buffer flush");
   int_hold_a: assert property (intFlag[0] && !(stWr[0] && writedata[2]) |=> intFlag[0])
      else $error("interrupt flag dropped without write of one");
   err_hold_a: assert property (errFlag[0] && !(stWr[0] && writedata[1]) |=> errFlag[0])
      else $error("error flag dropped without write of one");
   mem_error_a: assert property (eng[0].memError |=> errFlag[0] &&
                                 !active[0] && !($rose(intFlag[0]) && !$past(eng[0].bufEmpty)))
      else $error("memory error did not stop and flag");
   start_run_a: assert property (startSet[0] && !eng[0].memError |=> active[0] && ctl[0].startPulse)
      else $error("start did not set running flag");
   stop_run_a: assert property (startClr[0] |=> !active[0])
      else $error("clearing start left running flag set");
   eot_flush_a: assert property ($fell(active[0]) && !$past(startClr[0]) && !$past(eng[0].memError)
                                 |-> $past(eng[0].bufEmpty))
      else $error("running flag dropped with data still buffered");
   ptr_align_a: assert property (tablePtr[1][1:0] == 2'b00)
      else $error("pointer reserved bits not zero");
   legacy_off_a: assert property (!$past(mode_q[dbmsp_pkg::MODE_IOEN]) |-> legacyIrqOe == '0)
      else $error("legacy line driven before io enable");
endmodule
`default_nettype wire

// ==== dv/dbmsp_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbmsp_far_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bench requests, one bit per channel
   input wire logic [1:0] irqLine,
   input wire logic [1:0] regionReq,
   input wire logic [1:0] eotReq,
   input wire logic [1:0] errReq,
   // flush delay after data arrives; zero answers at once
   input wire logic [3:0] lag,
   // engine view
   output var dbmsp_pkg::dbmsp_eng_t eng [dbmsp_pkg::NUM_CHAN]
);
   logic [3:0] cnt [2];
   always @(posedge clk or negedge nrst)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (!nrst)
         begin
            eng[c] <= '0;
            eng[c].bufEmpty <= 1'b1;
            cnt[c] <= 4'h0;
         end
         else
         begin
            eng[c].drvIrq <= irqLine[c];
            eng[c].regionDone <= regionReq[c];
            eng[c].memError <= errReq[c];
            // low 31 bits scrambled every cycle; the end flag bit is only set together with a region
            eng[c].descWord1 <= {eotReq[c] & regionReq[c], 31'($urandom)};
            if ((irqLine[c] & ~eng[c].drvIrq) | regionReq[c])
            begin
               cnt[c] <= lag;
               eng[c].bufEmpty <= (lag == 4'h0);
            end
            else
            begin
               cnt[c] <= (cnt[c] != 4'h0) ? cnt[c] - 4'h1 : 4'h0;
               eng[c].bufEmpty <= (cnt[c] <= 4'h1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk, nrst, read, write, waitrequest, intxNOe;
   logic [7:0] address, a;
   logic [31:0] writedata, readdata, p;
   logic [3:0] byteenable, lag;
   logic [1:0] legacyIrq, legacyIrqOe, irqLine, regionReq, eotReq, errReq;
   dbmsp_pkg::dbmsp_eng_t eng [dbmsp_pkg::NUM_CHAN];
   dbmsp_pkg::dbmsp_ctl_t ctl [dbmsp_pkg::NUM_CHAN];
   logic [31:0] tablePtr [dbmsp_pkg::NUM_CHAN];
   logic [31:0] expQ [$];
   int err_count = 0;
   int samples_checked = 0;
   int pulses = 0;

   dbmsp_top #(.SIMPLEX_ONLY(1'b1)) uut (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .eng(eng), .ctl(ctl),
      .tablePtr(tablePtr), .legacyIrq(legacyIrq), .legacyIrqOe(legacyIrqOe),
      .intxNOe(intxNOe));
   dbmsp_far_model far (.clk(clk), .nrst(nrst), .irqLine(irqLine), .regionReq(regionReq),
      .eotReq(eotReq), .errReq(errReq), .lag(lag), .eng(eng));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // slave latency is its own business: wait for the ack, bounded
   task automatic waitAck();
      int n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0)
      begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic busWr(input logic [7:0] ad, input logic [31:0] d);
      address <= ad;
      writedata <= d;
      write <= 1'b1;
      waitAck();
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic busRd(input logic [7:0] ad, input logic [31:0] exp);
      expQ.push_back(exp);
      address <= ad;
      read <= 1'b1;
      waitAck();
      read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic fire(input logic [1:0] r, input logic [1:0] e, input logic end_of_table_flag);
      regionReq <= r;
      errReq <= e;
      eotReq <= {2{end_of_table_flag}};
      @(posedge clk);
      regionReq <= 2'b00;
      errReq <= 2'b00;
   endtask

   task automatic pins(input logic [31:0] exp);
      repeat (2) @(posedge clk);
      chk({27'h0, legacyIrqOe, legacyIrq, intxNOe}, exp);
   endtask

   // read data is taken only at the acknowledge edge
   always @(posedge clk)
   begin
      if (ctl[0].startPulse === 1'b1)
         pulses++;
      if (read === 1'b1 && waitrequest === 1'b0)
      begin
         if (expQ.size() == 0)
         begin
            err_count++;
            $display("MISMATCH at %0t: read answered with no expectation", $time);
         end
         else
            chk(readdata, expQ.pop_front());
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end

   initial
   begin
      nrst = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      lag = 4'h0;
      irqLine = 2'b00;
      regionReq = 2'b00;
      eotReq = 2'b00;
      errReq = 2'b00;
      void'($urandom(10));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      busRd(8'h08, 32'h0000_0080);
      busRd(8'h28, 32'h0000_0080);
      busRd(8'h3C, 32'h0000_0000);
      chk({30'h0, legacyIrqOe}, 32'h0);
      busWr(8'h08, 32'h0000_00FF);
      busRd(8'h08, 32'h0000_00E0);
      busWr(8'h08, 32'h0000_0000);
      busRd(8'h08, 32'h0000_0080);
      for (int i = 0; i < 2; i++)
      begin
         a = 8'h10 + 8'(i * 32);
         p = $urandom;
         // channel 0 keeps the table aligned, channel 1 pokes the reserved bits
         p[1:0] = 2'(i * 3);
         busRd(a, 32'h0);
         busWr(a, p);
         busRd(a, p & 32'hFFFF_FFFC);
         chk(tablePtr[i], p & 32'hFFFF_FFFC);
      end
      lag <= 4'h8;
      irqLine[0] <= 1'b1;
      busRd(8'h08, 32'h0000_0080);
      repeat (12) @(posedge clk);
      busRd(8'h08, 32'h0000_0084);
      irqLine[0] <= 1'b0;
      busWr(8'h40, 32'h0000_0001);
      pins(32'h0000_001A);
      busWr(8'h40, 32'h0000_0003);
      pins(32'h0000_0013);
      busWr(8'h40, 32'h0000_0002);
      pins(32'h0000_0003);
      busWr(8'h08, 32'h0000_0000);
      busRd(8'h08, 32'h0000_0084);
      busWr(8'h08, 32'h0000_0004);
      busRd(8'h08, 32'h0000_0080);
      lag <= 4'h0;
      irqLine[1] <= 1'b1;
      repeat (4) @(posedge clk);
      busRd(8'h28, 32'h0000_0084);
      irqLine[1] <= 1'b0;
      busWr(8'h28, 32'h0000_0004);
      lag <= 4'h8;
      busWr(8'h00, 32'h0000_0009);
      @(posedge clk);
      chk(32'(pulses), 32'h1);
      chk({31'h0, ctl[0].running}, 32'h1);
      chk({31'h0, ctl[0].dirWrite}, 32'h1);
      busRd(8'h00, 32'h0000_0009);
      busRd(8'h08, 32'h0000_0081);
      fire(2'b01, 2'b00, 1'b0);
      repeat (12) @(posedge clk);
      busRd(8'h08, 32'h0000_0081);
      fire(2'b01, 2'b00, 1'b1);
      busRd(8'h08, 32'h0000_0081);
      repeat (12) @(posedge clk);
      busRd(8'h08, 32'h0000_0080);
      busWr(8'h00, 32'h0000_0000);
      busWr(8'h20, 32'h0000_0001);
      busRd(8'h28, 32'h0000_0081);
      busRd(8'h08, 32'h0000_0080);
      busWr(8'h20, 32'h0000_0000);
      busRd(8'h28, 32'h0000_0080);
      busWr(8'h00, 32'h0000_0001);
      // fault arrives with data still buffered, so no interrupt may sneak in
      fire(2'b01, 2'b01, 1'b0);
      repeat (12) @(posedge clk);
      busRd(8'h08, 32'h0000_0082);
      busWr(8'h08, 32'h0000_0000);
      busRd(8'h08, 32'h0000_0082);
      busWr(8'h08, 32'h0000_0002);
      busRd(8'h08, 32'h0000_0080);
      busWr(8'h00, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(32'(expQ.size()), 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
